// [dv/resistive_temperature_sequencer_tb.sv]
// Purpose: self-checking bench of the temperature sequencer
// Assumes: shortened counts: cycles 64/256, half mains 100/80
// Notes: driver queues expectations, negedge monitors compare
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"
module resistive_temperature_sequencer_tb;
  // ----------------------------------------
  // Signals, instances, monitors
  // ----------------------------------------
  localparam int HLO = 100;
  localparam int HHI = 80;
  localparam logic [7:0] AC0 = 8'({`RTS_IDX_CFG0, 2'b00});
  localparam logic [7:0] AC6 = 8'({`RTS_IDX_CFG6, 2'b00});
  localparam logic [7:0] ACM = 8'({`RTS_IDX_CMD, 2'b00});
  localparam logic [7:0] AST = 8'({`RTS_IDX_STAT, 2'b00});
  localparam logic [7:0] ARS = 8'({`RTS_IDX_RES0, 2'b00});
  localparam logic [7:0] RA [6] = '{AC0, AC6, ACM, AST, 8'h3c, 8'h02};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sense_path;
  logic [3:0] port_drive;
  logic load_charge;
  logic busy;
  logic irq_flag;
  logic inv = 1'b1;
  logic [63:0] dly = 64'h0;
  logic [32:0] rd_q[$];
  bit use_q[$];
  logic [3:0] port_q[$];
  logic [3:0] pd_q = 4'h0;
  logic [3:0] ep;
  logic irq_q = 1'b0;
  logic lc_q = 1'b0;
  logic armed = 1'b0;
  int gap = 0;
  int last_gap = 0;
  int fail_count = 0;
  int num_checks = 0;
  integer seed = 32'h23db;
  rts_sequencer #(.TCYC_SHORT_CYC(64), .TCYC_LONG_CYC(256),
    .HALF_LO_CYC(HLO), .HALF_HI_CYC(HHI), .CHARGE_CYC(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense_path(sense_path),
    .port_drive(port_drive), .load_charge(load_charge), .busy(busy),
    .irq_flag(irq_flag));
  rts_sensor_model model_u (.pclk(pclk), .presetn(presetn),
    .port_drive(port_drive), .invert(inv), .dly(dly),
    .sense_path(sense_path));
  always #25 pclk = ~pclk;
  // Negedge sampling keeps clear of the design's own updates
  always @(negedge pclk) begin
    pd_q <= port_drive;
    irq_q <= irq_flag;
    lc_q <= load_charge;
    gap <= gap + 1;
    if (irq_flag && !irq_q) begin
      gap <= 0;
      armed <= 1'b1;
    end else if (armed && load_charge && !lc_q) begin
      armed <= 1'b0;
      last_gap <= gap;
    end
    if (psel && penable && !pwrite && rd_q.size() > 0) begin
      if (use_q.pop_front()) begin
        chk("prdata", {pslverr, prdata}, rd_q[0]);
      end
      void'(rd_q.pop_front());
    end
    if (port_drive != 4'h0 && pd_q == 4'h0) begin
      ep = port_q.size() > 0 ? port_q.pop_front() : 4'h0;
      chk("port", {29'h0, port_drive}, {29'h0, ep});
    end
  end
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [32:0] seen,
                     input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input bit u, output logic [31:0] q);
    rd_q.push_back(e);
    use_q.push_back(u);
    apb(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic rng(input int k, input int d);
    logic [31:0] q;
    rd(ARS + 8'(4 * k), 33'h0, 1'b0, q);
    chk("result", {32'h0, q >= d - 2 && q <= d + 8}, 33'h1);
  endtask : rng
  task automatic wait_for(input bit irq);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(negedge pclk);
      if (irq ? irq_flag === 1'b1 : busy === 1'b0) break;
    end
    // A wait that runs out ends the run as a failure
    if (i == 20000) begin
      fail_count++;
      close_out();
    end
  endtask : wait_for
  task automatic run(input logic [31:0] c0, input logic [31:0] c6,
                     input logic [31:0] cmd);
    logic [3:0] ord [4];
    for (int i = 0; i < 4; i++) begin
      ord[i] = c0[17] ? 4'(1 << (c6[11] ? 3 - i : i))
                      : 4'(1 << (c6[11] ^ i[0]));
    end
    for (int p = 0; p < (cmd[1] ? 2 : 1); p++) begin
      repeat (c0[15] ? 7 : 2) port_q.push_back(ord[0]);
      for (int i = 0; i < 4; i++) port_q.push_back(ord[i]);
    end
    inv <= c6[30];
    wr(AC0, c0);
    wr(AC6, c6);
    wr(ACM, cmd);
  endtask : run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    int d;
    int e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], {i > 3, `RTS_RESET_CFG}, 1'b1, q);
    end
    r = $random(seed);
    wr(AC6, r);
    rd(AC6, {1'b0, r}, 1'b1, q);
    // Four ports up, long cycle, one short and one open port
    d = 60 + ($random(seed) & 63);
    dly <= {16'h96, 16'h0, 16'h14, 16'(d)};
    run(32'h00030000, 32'h40000000, 32'h1);
    wr(AC0, 32'h00008000);
    wr(ACM, 32'h1);
    rd(AST, 33'h1, 1'b1, q);
    wait_for(1'b0);
    repeat (3) @(negedge pclk);
    chk("busy", {32'h0, busy}, 33'h0);
    chk("left", 33'(port_q.size()), 33'h0);
    rd(AST, 33'h2, 1'b1, q);
    wr(AST, 32'h2);
    rd(AST, 33'h0, 1'b1, q);
    rng(0, d);
    rd(ARS + 8'h4, 33'h0, 1'b1, q);
    rd(ARS + 8'h8, {1'b0, `RTS_RES_OPEN}, 1'b1, q);
    rng(3, 150);
    // Two ports reversed, seven dummies, stop not inverted
    d = 60 + ($random(seed) & 63);
    dly <= {32'h0, 16'h14, 16'(d)};
    run(32'h00018000, 32'h00000800, 32'h1);
    wait_for(1'b0);
    chk("left", 33'(port_q.size()), 33'h0);
    rd(ARS, 33'h0, 1'b1, q);
    rng(1, d);
    rd(ARS + 8'h8, 33'h0, 1'b1, q);
    rng(3, d);
    wr(AST, 32'h2);
    // Repeat runs over every delay code and both mains bases
    dly <= 64'h0;
    for (int c = 0; c < 4; c++) begin
      r = 32'h40000000 | (32'(c) << 18) | (32'(c & 1) << 15);
      e = (2 + c) * ((c & 1) ? HHI : HLO);
      run(32'h0, r, 32'h2);
      wait_for(1'b1);
      rd(AST, 33'h7, 1'b1, q);
      wr(AST, 32'h2);
      wait_for(1'b1);
      chk("again", {32'h0, irq_flag}, 33'h1);
      wait_for(1'b0);
      chk("gap", {32'h0, last_gap >= e - 2 && last_gap <= e + 8},
          33'h1);
      chk("left", 33'(port_q.size()), 33'h0);
      for (int k = 0; k < 4; k++) begin
        rd(ARS + 8'(4 * k), {1'b0, `RTS_RES_OPEN}, 1'b1, q);
      end
      wr(AST, 32'h2);
    end
    close_out();
  end
endmodule : resistive_temperature_sequencer_tb
`default_nettype wire

// [dv/rts_checker.sv]
// Purpose: port assertions of the temperature sequencer
// Assumes: cmd at byte 0x20, status at 0x24, done flag in bit 1
// Notes: bound to rts_sequencer; cycle lengths passed from it
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"
module rts_checker #(
  parameter int TCYC_SHORT_CYC = `RTS_TCYC_SHORT_CYC,
  parameter int TCYC_LONG_CYC = `RTS_TCYC_LONG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] port_drive,
  input wire logic load_charge,
  input wire logic busy,
  input wire logic irq_flag
);
  // ----------------------------------------
  // Helper logic and assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire w1c = acc && pwrite && paddr == 8'h24 && pwdata[1];
  logic lc_d, irq_d;
  int gap;
  // Saturates after reset and at each flag rise, so no delay is judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_d <= 1'b0;
      irq_d <= 1'b0;
      gap <= 1000;
    end else begin
      lc_d <= load_charge;
      irq_d <= irq_flag;
      if (irq_flag && !irq_d) begin
        gap <= 1000;
      end else begin
        gap <= (load_charge && !lc_d) ? 1 : (gap < 1000 ? gap + 1 : gap);
      end
    end
  end
  zero_wait_a: assert property (acc |-> pready)
    else $error("pready low in access phase");
  bad_addr_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  start_busy_a: assert property (
    acc && pwrite && paddr == 8'h20 && pwdata[1:0] != 2'b00 && !busy
    |=> busy) else $error("start command did not set busy");
  one_port_a: assert property ($onehot0(port_drive))
    else $error("more than one port driven");
  charge_gap_a: assert property (
    load_charge |-> port_drive == 4'h0)
    else $error("port driven while charging");
  idle_quiet_a: assert property (
    !busy |-> port_drive == 4'h0 && !load_charge)
    else $error("activity while idle");
  charge_len_a: assert property (
    $rose(load_charge) |-> load_charge[*8] ##[1:4] !load_charge)
    else $error("charge phase length wrong");
  dis_bound_a: assert property (
    $rose(port_drive != 4'h0) |-> ##[1:300] port_drive == 4'h0)
    else $error("discharge outlasts the cycle");
  cycle_len_a: assert property (
    $rose(load_charge) && gap < 300 |->
    gap == TCYC_SHORT_CYC || gap == TCYC_LONG_CYC)
    else $error("charge spacing is not a cycle length");
  end_flag_a: assert property ($fell(busy) |-> irq_flag)
    else $error("measurement ended without flag");
  flag_hold_a: assert property (irq_flag && !w1c |=> irq_flag)
    else $error("flag dropped without clear");
  cover property ($rose(irq_flag));
  cover property (port_drive == 4'h8);
  cover property (acc && pslverr);
endmodule : rts_checker

bind rts_sequencer rts_checker #(.TCYC_SHORT_CYC(TCYC_SHORT_CYC),
  .TCYC_LONG_CYC(TCYC_LONG_CYC)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .port_drive(port_drive), .load_charge(load_charge), .busy(busy),
  .irq_flag(irq_flag));
`default_nettype wire

// [dv/rts_sensor_model.sv]
// Purpose: resistor ports, load capacitor and comparator
// Assumes: delay zero means the port never trips (open sensor)
// Notes: comparator output is always driven, level only
`timescale 1ns/1ps
`default_nettype none
module rts_sensor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] port_drive,
  input wire logic invert,
  input wire logic [63:0] dly,
  output logic sense_path
);
  // ----------------------------------------
  // Discharge timing per port
  // ----------------------------------------
  logic [15:0] cnt;
  logic [15:0] d;
  logic stop;
  always_comb begin
    d = 16'h0;
    for (int i = 0; i < 4; i++) begin
      if (port_drive[i]) begin
        d = dly[16*i +: 16];
      end
    end
  end
  assign stop = (port_drive != 4'h0) && (d != 16'h0) && (cnt >= d);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0;
      sense_path <= invert;
    end else begin
      cnt <= (port_drive != 4'h0) ? cnt + 16'h1 : 16'h0;
      sense_path <= stop ^ invert;
    end
  end
endmodule : rts_sensor_model
`default_nettype wire

// [src/rts_consts.svh]
// Purpose: constants of the resistive temperature sequencer
// Assumes: 20 MHz pclk; APB data 32 bits, one word per register
// Notes: timing counts derive from the figures below
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define RTS_IDX_CFG0 4'h0
`define RTS_IDX_CFG6 4'h6
`define RTS_IDX_CMD 4'h8
`define RTS_IDX_STAT 4'h9
`define RTS_IDX_RES0 4'ha
`define RTS_RESET_CFG 32'h00000000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTS_B_DUMMY 15
`define RTS_B_CYCLE 16
`define RTS_B_PORTS 17
`define RTS_B_ORDER 11
`define RTS_B_MAINS 15
`define RTS_B_DELAY 18
`define RTS_B_INVERT 30
`define RTS_B_CMD_ONE 0
`define RTS_B_CMD_REP 1
`define RTS_B_ST_BUSY 0
`define RTS_B_ST_DONE 1
`define RTS_B_ST_PASS 2

// ----------------------------------------------------------------
// Counts and timing
// ----------------------------------------------------------------
`define RTS_DUMMY_FEW 4'h2
`define RTS_DUMMY_MANY 4'h7
`define RTS_REAL_STEPS 4'h4
`define RTS_RES_SHORT 32'h00000000
`define RTS_RES_OPEN 32'h0fffffff
`define RTS_CLK_MHZ 20
`define RTS_TCYC_SHORT_US 128
`define RTS_TCYC_LONG_US 512
`define RTS_SHORT_US 2
`define RTS_CHARGE_US 10
`define RTS_MAINS_LO_HZ 50
`define RTS_MAINS_HI_HZ 60
`define RTS_TCYC_SHORT_CYC (`RTS_CLK_MHZ * `RTS_TCYC_SHORT_US)
`define RTS_TCYC_LONG_CYC (`RTS_CLK_MHZ * `RTS_TCYC_LONG_US)
`define RTS_SHORT_CYC (`RTS_CLK_MHZ * `RTS_SHORT_US)
`define RTS_CHARGE_CYC (`RTS_CLK_MHZ * `RTS_CHARGE_US)
`define RTS_HALF_LO_CYC ((`RTS_CLK_MHZ * 1000000) / (2 * `RTS_MAINS_LO_HZ))
`define RTS_HALF_HI_CYC ((`RTS_CLK_MHZ * 1000000) / (2 * `RTS_MAINS_HI_HZ))

`endif

// [src/rts_discharge.sv]
// Purpose: one charge and discharge cycle with time measurement
// Assumes: stop is synchronised and already polarity corrected
// Notes: done pulses once at the end of the whole cycle
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"
module rts_discharge
  import rts_pkg::*;
#(
  parameter int CW = 16,
  parameter int CHARGE_CYC = `RTS_CHARGE_CYC,
  parameter int SHORT_CYC = `RTS_SHORT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [CW-1:0] cycle_len,
  input wire logic stop,
  output logic charge,
  output logic discharge,
  output rts_result_s result
);

  rts_dis_e state, next_state;
  logic [CW-1:0] cnt, next_cnt, dcnt, next_dcnt;
  rts_result_s next_result;

  if (CW < 2 || CHARGE_CYC < 1 || CHARGE_CYC >= (1 << CW) ||
      SHORT_CYC >= (1 << CW)) begin : g_bad_count
    $error("rts_discharge: counts do not fit the counter");
  end

  assign charge = (state == RTS_D_CHG);
  assign discharge = (state == RTS_D_DIS);

  always_comb begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_dcnt = dcnt;
    next_result = result;
    next_result.done = 1'b0;
    unique case (state)
      RTS_D_IDLE: begin
        next_cnt = '0;
        if (start) begin
          next_state = RTS_D_CHG;
        end
      end
      RTS_D_CHG: begin
        next_dcnt = '0;
        if (cnt == CW'(CHARGE_CYC - 1)) begin
          next_state = RTS_D_DIS;
        end
      end
      RTS_D_DIS: begin
        next_dcnt = dcnt + 1'b1;
        if (stop) begin
          next_state = RTS_D_TAIL;
          if (dcnt < CW'(SHORT_CYC)) begin
            next_result.value = `RTS_RES_SHORT;
          end else begin
            next_result.value = 32'(dcnt);
          end
        end else if (cnt >= cycle_len - 1'b1) begin
          next_result.value = `RTS_RES_OPEN;
          next_result.done = 1'b1;
          next_state = RTS_D_IDLE;
        end
      end
      RTS_D_TAIL: begin
        // Keep the cycle length fixed, whatever the stop time
        if (cnt >= cycle_len - 1'b1) begin
          next_result.done = 1'b1;
          next_state = RTS_D_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RTS_D_IDLE;
      cnt <= '0;
      dcnt <= '0;
      result <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      dcnt <= next_dcnt;
      result <= next_result;
    end
  end

endmodule : rts_discharge
`default_nettype wire

// [src/rts_pkg.sv]
// Purpose: types of the resistive temperature sequencer
// Assumes: constants live in rts_consts.svh
// Notes: configuration travels as one snapshot struct
`default_nettype none
package rts_pkg;

  typedef struct packed {
    logic many_dummy;
    logic long_cycle;
    logic four_ports;
    logic reverse;
    logic mains_hi;
    logic [1:0] delay_code;
    logic invert;
  } rts_cfg_s;

  typedef struct packed {
    logic done;
    logic [31:0] value;
  } rts_result_s;

  typedef enum logic [1:0] {
    RTS_IDLE = 2'b00,
    RTS_FIRE = 2'b01,
    RTS_WAITC = 2'b11,
    RTS_DELAY = 2'b10
  } rts_seq_e;

  typedef enum logic [1:0] {
    RTS_D_IDLE = 2'b00,
    RTS_D_CHG = 2'b01,
    RTS_D_DIS = 2'b11,
    RTS_D_TAIL = 2'b10
  } rts_dis_e;

endpackage : rts_pkg
`default_nettype wire

// [src/rts_sequencer.sv]
// Purpose: APB slave and sequencer of the temperature measurement
// Assumes: sense_path comes from the comparator, asynchronous to pclk
// Notes: results update one by one as each real discharge ends
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int TCYC_SHORT_CYC = `RTS_TCYC_SHORT_CYC,
  parameter int TCYC_LONG_CYC = `RTS_TCYC_LONG_CYC,
  parameter int HALF_LO_CYC = `RTS_HALF_LO_CYC,
  parameter int HALF_HI_CYC = `RTS_HALF_HI_CYC,
  parameter int CHARGE_CYC = `RTS_CHARGE_CYC,
  parameter int CW = 16,
  parameter int MW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sense_path,
  output logic [3:0] port_drive,
  output logic load_charge,
  output logic busy,
  output logic irq_flag
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (TCYC_LONG_CYC >= (1 << CW) || CHARGE_CYC + 2 >= TCYC_SHORT_CYC ||
        TCYC_SHORT_CYC < 4) begin : g_bad_cycle
      $error("rts_sequencer: cycle counts do not fit");
    end
    if (HALF_LO_CYC >= (1 << MW) || HALF_HI_CYC >= (1 << MW) ||
        HALF_HI_CYC < 2) begin : g_bad_mains
      $error("rts_sequencer: mains counts do not fit");
    end
  endgenerate

  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    reg_index = addr[5:2];
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    logic [3:0] i;
    i = reg_index(addr);
    mapped = (addr[1:0] == 2'b00) && (addr[7:6] == 2'b00) &&
             (i == `RTS_IDX_CFG0 || i == `RTS_IDX_CFG6 ||
              i == `RTS_IDX_CMD || i == `RTS_IDX_STAT ||
              (i >= `RTS_IDX_RES0 && i <= `RTS_IDX_RES0 + 4'h3));
  endfunction

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [31:0] cfg0, next_cfg0, cfg6, next_cfg6;
  logic [31:0] next_prdata;
  logic next_pslverr, done_flag, next_done_flag;
  logic [31:0] res_mem [4];
  logic wr_acc, cmd_one, cmd_rep, clr_done, set_done;
  logic [3:0] widx;
  rts_seq_e state, next_state;
  logic pass2;

  assign pready = psel & penable;
  assign wr_acc = psel & penable & pwrite;
  assign widx = reg_index(paddr);
  assign cmd_one = wr_acc && mapped(paddr) && widx == `RTS_IDX_CMD &&
                   pwdata[`RTS_B_CMD_ONE];
  assign cmd_rep = wr_acc && mapped(paddr) && widx == `RTS_IDX_CMD &&
                   pwdata[`RTS_B_CMD_REP];
  assign clr_done = wr_acc && mapped(paddr) && widx == `RTS_IDX_STAT &&
                    pwdata[`RTS_B_ST_DONE];
  assign irq_flag = done_flag;
  assign busy = (state != RTS_IDLE);

  always_comb begin
    next_cfg0 = cfg0;
    next_cfg6 = cfg6;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pslverr = !mapped(paddr);
      next_prdata = 32'h00000000;
      if (mapped(paddr) && !pwrite) begin
        if (widx == `RTS_IDX_CFG0) begin
          next_prdata = cfg0;
        end else if (widx == `RTS_IDX_CFG6) begin
          next_prdata = cfg6;
        end else if (widx == `RTS_IDX_STAT) begin
          next_prdata[`RTS_B_ST_BUSY] = busy;
          next_prdata[`RTS_B_ST_DONE] = done_flag;
          next_prdata[`RTS_B_ST_PASS] = pass2;
        end else if (widx >= `RTS_IDX_RES0) begin
          next_prdata = res_mem[2'(widx - `RTS_IDX_RES0)];
        end
      end
    end
    if (wr_acc && mapped(paddr)) begin
      if (widx == `RTS_IDX_CFG0) begin
        next_cfg0 = pwdata;
      end
      if (widx == `RTS_IDX_CFG6) begin
        next_cfg6 = pwdata;
      end
    end
    // Set wins over a clear in the same cycle
    next_done_flag = set_done | (done_flag & !clr_done);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0 <= `RTS_RESET_CFG;
      cfg6 <= `RTS_RESET_CFG;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      cfg0 <= next_cfg0;
      cfg6 <= next_cfg6;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      done_flag <= next_done_flag;
    end
  end

  // ----------------------------------------------------------------
  // Sense input synchroniser
  // ----------------------------------------------------------------
  logic sense_s1, sense_s2, stop;
  rts_cfg_s cfg, next_cfg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_s1 <= 1'b0;
      sense_s2 <= 1'b0;
    end else begin
      sense_s1 <= sense_path;
      sense_s2 <= sense_s1;
    end
  end

  assign stop = sense_s2 ^ cfg.invert;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [3:0] step, next_step, ndummy;
  logic [1:0] real_idx, port, next_port;
  logic next_pass2, repeat_run, next_repeat_run, fire;
  logic [MW-1:0] mcnt, next_mcnt;
  logic [2:0] halves, next_halves;
  logic [CW-1:0] cycle_len;
  logic [MW-1:0] half_len;
  logic [3:0] next_drive;
  rts_result_s dres;
  logic dis_on;

  assign ndummy = cfg.many_dummy ? `RTS_DUMMY_MANY : `RTS_DUMMY_FEW;
  assign cycle_len = cfg.long_cycle ? CW'(TCYC_LONG_CYC) :
                     CW'(TCYC_SHORT_CYC);
  assign half_len = cfg.mains_hi ? MW'(HALF_HI_CYC) : MW'(HALF_LO_CYC);
  assign real_idx = (step >= ndummy) ? 2'(step - ndummy) : 2'b00;
  assign fire = (state == RTS_FIRE);

  always_comb begin
    logic [1:0] k;
    k = cfg.four_ports ? real_idx : {1'b0, real_idx[0]};
    // reversed dummies land on the last port
    if (cfg.reverse) begin
      next_port = cfg.four_ports ? 2'(3 - k) : 2'(1 - k);
    end else begin
      next_port = k;
    end
  end

  always_comb begin
    next_state = state;
    next_step = step;
    next_pass2 = pass2;
    next_repeat_run = repeat_run;
    next_cfg = cfg;
    next_mcnt = mcnt;
    next_halves = halves;
    set_done = 1'b0;
    unique case (state)
      RTS_IDLE: begin
        if (cmd_one || cmd_rep) begin
          next_cfg.many_dummy = cfg0[`RTS_B_DUMMY];
          next_cfg.long_cycle = cfg0[`RTS_B_CYCLE];
          next_cfg.four_ports = cfg0[`RTS_B_PORTS];
          next_cfg.reverse = cfg6[`RTS_B_ORDER];
          next_cfg.mains_hi = cfg6[`RTS_B_MAINS];
          next_cfg.delay_code = cfg6[`RTS_B_DELAY +: 2];
          next_cfg.invert = cfg6[`RTS_B_INVERT];
          next_repeat_run = cmd_rep;
          next_pass2 = 1'b0;
          next_step = 4'h0;
          next_state = RTS_FIRE;
        end
      end
      RTS_FIRE: begin
        next_state = RTS_WAITC;
      end
      RTS_WAITC: begin
        if (dres.done) begin
          if (step == ndummy + `RTS_REAL_STEPS - 4'h1) begin
            set_done = 1'b1;
            next_step = 4'h0;
            if (repeat_run && !pass2) begin
              next_pass2 = 1'b1;
              next_mcnt = '0;
              next_halves = 3'h0;
              next_state = RTS_DELAY;
            end else begin
              next_state = RTS_IDLE;
            end
          end else begin
            next_step = step + 4'h1;
            next_state = RTS_FIRE;
          end
        end
      end
      RTS_DELAY: begin
        // delay in half mains periods, two plus code
        next_mcnt = mcnt + 1'b1;
        if (mcnt == half_len - 1'b1) begin
          next_mcnt = '0;
          next_halves = halves + 3'h1;
          if (halves == 3'(cfg.delay_code) + 3'h1) begin
            next_state = RTS_FIRE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RTS_IDLE;
      step <= 4'h0;
      pass2 <= 1'b0;
      repeat_run <= 1'b0;
      cfg <= '0;
      mcnt <= '0;
      halves <= 3'h0;
      port <= 2'b00;
    end else begin
      state <= next_state;
      step <= next_step;
      pass2 <= next_pass2;
      repeat_run <= next_repeat_run;
      cfg <= next_cfg;
      mcnt <= next_mcnt;
      halves <= next_halves;
      if (fire) begin
        port <= next_port;
      end
    end
  end

  // ----------------------------------------------------------------
  // Discharge timer and results
  // ----------------------------------------------------------------
  // charge, then time the discharge through the selected port
  rts_discharge #(
    .CW(CW),
    .CHARGE_CYC(CHARGE_CYC),
    .SHORT_CYC(`RTS_SHORT_CYC)
  ) u_dis (
    .pclk(pclk),
    .presetn(presetn),
    .start(fire),
    // Done and fire cycles make up the rest of the period
    .cycle_len(cycle_len - CW'(2)),
    .stop(stop),
    .charge(load_charge),
    .discharge(dis_on),
    .result(dres)
  );

  // one driver enable per resistor port
  always_comb begin
    next_drive = 4'h0;
    if (dis_on) begin
      next_drive[port] = 1'b1;
    end
  end
  assign port_drive = next_drive;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_res
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          res_mem[gi] <= 32'h00000000;
        end else if (state == RTS_WAITC && dres.done &&
                     step >= ndummy && real_idx == 2'(gi)) begin
          res_mem[gi] <= dres.value;
        end
      end
    end
  endgenerate

endmodule : rts_sequencer
`default_nettype wire
